// [dnsd_defs.svh]
// Register offsets, field positions and reset values for the DDC sync block
`ifndef DNSD_DEFS_SVH
`define DNSD_DEFS_SVH
// ======================================
// Register byte offsets
`define DNSD_ADDR_CTRL 8'h00
`define DNSD_ADDR_ARM 8'h04
`define DNSD_ADDR_STAT 8'h08
`define DNSD_ADDR_FRQA 8'h10
`define DNSD_ADDR_FRQB 8'h14
`define DNSD_ADDR_PHSA 8'h18
`define DNSD_ADDR_PHSB 8'h1c
// ======================================
// Control register fields
`define DNSD_CTRL_LINK_EN 0
`define DNSD_CTRL_PIN_ALIGN 1
`define DNSD_CTRL_ENC64 2
`define DNSD_CTRL_DEC_LO 4
`define DNSD_CTRL_DEC_HI 6
// ======================================
// Arm and status fields
`define DNSD_ARM_BIT 0
`define DNSD_STAT_ARM 0
`define DNSD_STAT_CGS 1
`define DNSD_STAT_TRIG 2
`define DNSD_STAT_CNT_LO 8
`define DNSD_STAT_CNT_HI 15
// ======================================
// Reset values
`define DNSD_CTRL_RST 32'h0000_0000
`define DNSD_WORD_RST 32'h0000_0000
`define DNSD_PHASE_RST 16'h0000
`endif

// [dnsd_pkg.sv]
// Types and shared arithmetic of the DDC sync and decimation block
package dnsd_pkg;
   // SYNC handshake progress
   typedef enum logic [1:0] {DNSD_HS_IDLE = 2'b00, DNSD_HS_CGS = 2'b01,
      DNSD_HS_TRIG = 2'b10} dnsd_hs_t;
   // Overall decimation selection
   typedef enum logic [2:0] {DNSD_BYPASS = 3'b000, DNSD_DEC4 = 3'b001, DNSD_DEC8 = 3'b010,
      DNSD_DEC16 = 3'b011, DNSD_DEC32 = 3'b100} dnsd_dec_t;
   // Round half up, shift by the stage scale, saturate to 15 bits
   function automatic logic signed [14:0] dnsd_rnd_sat(input logic signed [47:0] a,
      input int sh);
      logic signed [47:0] r;
      r = (a + (48'sh0000_0000_0001 <<< (sh - 1))) >>> sh;
      if (r > 48'sh0000_0000_3fff) return 15'sh3fff;
      if (r < -48'sh0000_0000_4000) return 15'sh4000;
      return r[14:0];
   endfunction
endpackage

// [dnsd_rx_model.sv]
// Behavioural link receiver model that drives the SYNC request line
module dnsd_rx_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bench control: start request, encoding, release delay
   input wire logic link_go,
   input wire logic enc64,
   input wire logic [7:0] hold,
   // Device side
   input wire logic cgs_start_ff,
   output logic sync_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] st_ff;
   logic [7:0] cnt_ff;
   logic sync_ff;
   // ======================================
   // Handshake: high while idle, low on start, high again once ready
   // The hold count lets a scenario release promptly or slowly
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= 2'h0;
         cnt_ff <= 8'h00;
         sync_ff <= 1'b1;
      end else if (!link_go) begin
         st_ff <= 2'h0;
         sync_ff <= 1'b1;
      end else if (st_ff == 2'h0) begin
         st_ff <= 2'h1;
         sync_ff <= 1'b0;
      end else if (st_ff == 2'h1 && (cgs_start_ff || enc64)) begin
         st_ff <= 2'h2;
         cnt_ff <= hold;
      end else if (st_ff == 2'h2) begin
         if (cnt_ff == 8'h00) begin
            st_ff <= 2'h3;
            sync_ff <= 1'b1;
         end else begin
            cnt_ff <= cnt_ff - 8'h01;
         end
      end
   end
   // Line is push-pull, so it always shows the driven level
   assign sync_pin = sync_ff;
endmodule // dnsd_rx_model

// [dnsd_top.sv]
// Oscillator alignment control and complex half-band decimation chain
//
// Chosen here: the APB interface to the registers and the address map.

// ======================================
// Half-band stage: folded symmetric FIR, decimate by two
module dnsd_hb
   import dnsd_pkg::*;
#(
   parameter int N = 2,
   parameter int SH = 5,
   parameter int CEN = 16,
   parameter int C [14] = '{default: 0}
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Input samples
   input wire logic in_valid,
   input wire logic signed [14:0] in_i,
   input wire logic signed [14:0] in_q,
   // Decimated samples
   output logic out_valid_ff,
   output logic signed [14:0] out_i_ff,
   output logic signed [14:0] out_q_ff
);
   localparam int L = 4 * N - 1;
   logic signed [14:0] di_ff [L];
   logic signed [14:0] dq_ff [L];
   logic phase_ff;
   logic pend_ff;
   logic signed [47:0] acc_i;
   logic signed [47:0] acc_q;

   // Delay line advances once per input sample
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < L; k++) begin
            di_ff[k] <= 15'h0000;
            dq_ff[k] <= 15'h0000;
         end
      end else if (in_valid) begin
         di_ff[0] <= in_i;
         dq_ff[0] <= in_q;
         for (int k = 1; k < L; k++) begin
            di_ff[k] <= di_ff[k-1];
            dq_ff[k] <= dq_ff[k-1];
         end
      end
   end

   // Every second input produces one output
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_ff <= 1'b0;
         pend_ff <= 1'b0;
      end else begin
         phase_ff <= phase_ff ^ in_valid;
         pend_ff <= in_valid & phase_ff;
      end
   end

   // Mirrored taps are summed first so each pair costs one multiply
   always_comb begin
      acc_i = 48'(CEN) * 48'(di_ff[2*N-1]);
      acc_q = 48'(CEN) * 48'(dq_ff[2*N-1]);
      for (int k = 0; k < N; k++) begin
         acc_i += 48'(C[k]) * 48'(16'(di_ff[2*k]) + 16'(di_ff[L-1-2*k]));
         acc_q += 48'(C[k]) * 48'(16'(dq_ff[2*k]) + 16'(dq_ff[L-1-2*k]));
      end
   end

   // Scaled and saturated result
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid_ff <= 1'b0;
         out_i_ff <= 15'h0000;
         out_q_ff <= 15'h0000;
      end else begin
         out_valid_ff <= pend_ff;
         if (pend_ff) begin
            out_i_ff <= dnsd_rnd_sat(acc_i, SH);
            out_q_ff <= dnsd_rnd_sat(acc_q, SH);
         end
      end
   end
endmodule // dnsd_hb

// ======================================
// Top: APB registers, alignment control, stage chain
module dnsd_top
   import dnsd_pkg::*;
(
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_ff,
   output logic pready_ff,
   output logic pslverr_ff,
   // Link pins, asynchronous
   input wire logic sync_pin,
   input wire logic sysref_pin,
   // Link and oscillator side
   output logic cgs_start_ff,
   output logic nco_align_ff,
   output logic [31:0] osc_freq_word_chan_a_ff,
   output logic [31:0] osc_freq_word_chan_b_ff,
   output logic [15:0] osc_phase_word_chan_a_ff,
   output logic [15:0] osc_phase_word_chan_b_ff,
   // Samples from mixer and converter core
   input wire logic in_valid,
   input wire logic signed [14:0] mix_i,
   input wire logic signed [14:0] mix_q,
   input wire logic [11:0] adc_real,
   input wire logic overrange_flag_i,
   input wire logic overrange_flag_q,
   // Output samples
   output logic out_valid_ff,
   output logic out_real_ff,
   output logic [15:0] out_i_ff,
   output logic [15:0] out_q_ff
);
   `include "dnsd_defs.svh"
   logic [31:0] ctrl_ff;
   logic arm_ff;
   dnsd_hs_t hs_ff;
   logic [7:0] align_cnt_ff;
   logic [2:0] sync_sh_ff;
   logic [2:0] sref_sh_ff;
   logic sync_fall, sync_rise, sref_rise, wr_en, arm_wr, sync_hit, sref_hit;
   logic link_en, pin_en, enc64;
   dnsd_dec_t dec;
   logic [31:0] nxt_rdata;
   logic nxt_err;

   assign link_en = ctrl_ff[`DNSD_CTRL_LINK_EN];
   assign pin_en = ctrl_ff[`DNSD_CTRL_PIN_ALIGN];
   assign enc64 = ctrl_ff[`DNSD_CTRL_ENC64];
   assign dec = dnsd_dec_t'(ctrl_ff[`DNSD_CTRL_DEC_HI:`DNSD_CTRL_DEC_LO]);

   // ======================================
   // APB access: setup cycle prepares answer, access completes with no wait
   assign wr_en = psel & penable & pready_ff & pwrite & ~pslverr_ff;
   assign arm_wr = wr_en & (paddr == `DNSD_ADDR_ARM) & pwdata[`DNSD_ARM_BIT];

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      nxt_err = 1'b0;
      unique case (paddr)
         `DNSD_ADDR_CTRL: nxt_rdata = ctrl_ff;
         `DNSD_ADDR_ARM: nxt_rdata = {31'h0000_0000, arm_ff};
         `DNSD_ADDR_STAT: nxt_rdata = {16'h0000, align_cnt_ff, 5'h00,
            hs_ff == DNSD_HS_TRIG, hs_ff == DNSD_HS_CGS, arm_ff};
         `DNSD_ADDR_FRQA: nxt_rdata = osc_freq_word_chan_a_ff;
         `DNSD_ADDR_FRQB: nxt_rdata = osc_freq_word_chan_b_ff;
         `DNSD_ADDR_PHSA: nxt_rdata = {16'h0000, osc_phase_word_chan_a_ff};
         `DNSD_ADDR_PHSB: nxt_rdata = {16'h0000, osc_phase_word_chan_b_ff};
         default: nxt_err = 1'b1; // Unmapped offsets answer with an error
      endcase
   end

   // Answer registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= psel & ~penable;
         pslverr_ff <= psel & ~penable & nxt_err;
         if (psel & ~penable & ~pwrite) prdata_ff <= nxt_rdata;
      end
   end

   // Writable configuration; frequency and phase words feed the oscillators
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= `DNSD_CTRL_RST;
         osc_freq_word_chan_a_ff <= `DNSD_WORD_RST;
         osc_freq_word_chan_b_ff <= `DNSD_WORD_RST;
         osc_phase_word_chan_a_ff <= `DNSD_PHASE_RST;
         osc_phase_word_chan_b_ff <= `DNSD_PHASE_RST;
      end else if (wr_en) begin
         unique case (paddr)
            `DNSD_ADDR_CTRL: ctrl_ff <= pwdata & 32'h0000_0077;
            `DNSD_ADDR_FRQA: osc_freq_word_chan_a_ff <= pwdata;
            `DNSD_ADDR_FRQB: osc_freq_word_chan_b_ff <= pwdata;
            `DNSD_ADDR_PHSA: osc_phase_word_chan_a_ff <= pwdata[15:0];
            `DNSD_ADDR_PHSB: osc_phase_word_chan_b_ff <= pwdata[15:0];
            default: ;
         endcase
      end
   end

   // ======================================
   // Pin synchronisers; bit 0 is read only by bit 1
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_sh_ff <= 3'h7; // SYNC idles high
         sref_sh_ff <= 3'h0;
      end else begin
         sync_sh_ff <= {sync_sh_ff[1:0], sync_pin};
         sref_sh_ff <= {sref_sh_ff[1:0], sysref_pin};
      end
   end
   assign sync_fall = sync_sh_ff[2] & ~sync_sh_ff[1];
   assign sync_rise = ~sync_sh_ff[2] & sync_sh_ff[1];
   assign sref_rise = ~sref_sh_ff[2] & sref_sh_ff[1];
   assign sync_hit = sync_rise & pin_en & (hs_ff != DNSD_HS_IDLE);
   assign sref_hit = sref_rise & arm_ff;

   // SYNC handshake runs regardless of any SYSREF arming
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_ff <= DNSD_HS_IDLE;
         cgs_start_ff <= 1'b0;
      end else begin
         cgs_start_ff <= 1'b0;
         unique case (hs_ff)
            DNSD_HS_IDLE: if (sync_fall & link_en) begin
               hs_ff <= enc64 ? DNSD_HS_TRIG : DNSD_HS_CGS;
               cgs_start_ff <= ~enc64;
            end
            DNSD_HS_CGS, DNSD_HS_TRIG: if (sync_rise | ~link_en) hs_ff <= DNSD_HS_IDLE;
            default: hs_ff <= DNSD_HS_IDLE;
         endcase
      end
   end

   // Arm flag: a new arming write wins over consumption in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) arm_ff <= 1'b0;
      else if (arm_wr) arm_ff <= 1'b1;
      else if (sref_hit) arm_ff <= 1'b0;
   end

   // One alignment pulse per cycle with a qualifying SYNC or SYSREF edge, or both
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nco_align_ff <= 1'b0;
         align_cnt_ff <= 8'h00;
      end else begin
         nco_align_ff <= sync_hit | sref_hit;
         if (sync_hit | sref_hit) align_cnt_ff <= align_cnt_ff + 8'h01;
      end
   end

   // ======================================
   // Stage chain; unused leading stages are skipped by the input muxes
   logic va, vb, vc, vd, ve;
   logic signed [14:0] ia, qa, ib, qb, ic, qc, id, qd, ie, qe;
   logic sb, sc, sd;
   assign sb = (dec == DNSD_DEC32);
   assign sc = (dec == DNSD_DEC32) | (dec == DNSD_DEC16);
   assign sd = sc | (dec == DNSD_DEC8);

   dnsd_hb #(.N(2), .SH(5), .CEN(16), .C('{0: -1, 1: 9, default: 0})) u_stage_a (
      .pclk(pclk), .presetn(presetn), .in_valid(in_valid), .in_i(mix_i), .in_q(mix_q),
      .out_valid_ff(va), .out_i_ff(ia), .out_q_ff(qa));
   dnsd_hb #(.N(2), .SH(11), .CEN(1024), .C('{0: -65, 1: 577, default: 0})) u_stage_b (
      .pclk(pclk), .presetn(presetn), .in_valid(sb ? va : in_valid), .in_i(sb ? ia : mix_i),
      .in_q(sb ? qa : mix_q), .out_valid_ff(vb), .out_i_ff(ib), .out_q_ff(qb));
   dnsd_hb #(.N(3), .SH(14), .CEN(8192), .C('{0: 109, 1: -837, 2: 4824, default: 0}))
      u_stage_c (.pclk(pclk), .presetn(presetn), .in_valid(sc ? vb : in_valid),
      .in_i(sc ? ib : mix_i), .in_q(sc ? qb : mix_q), .out_valid_ff(vc), .out_i_ff(ic),
      .out_q_ff(qc));
   dnsd_hb #(.N(4), .SH(17), .CEN(65536), .C('{0: -327, 1: 2231, 2: -8881, 3: 39742,
      default: 0})) u_stage_d (.pclk(pclk), .presetn(presetn), .in_valid(sd ? vc : in_valid),
      .in_i(sd ? ic : mix_i), .in_q(sd ? qc : mix_q), .out_valid_ff(vd), .out_i_ff(id),
      .out_q_ff(qd));
   dnsd_hb #(.N(14), .SH(19), .CEN(262144), .C('{-37, 118, -291, 612, -1159, 2031, -3356,
      5308, -8140, 12284, -18628, 29455, -53191, 166059})) u_stage_e (.pclk(pclk),
      .presetn(presetn), .in_valid(vd), .in_i(id), .in_q(qd), .out_valid_ff(ve),
      .out_i_ff(ie), .out_q_ff(qe));

   // Output word: sample on top, over-range in bit 0; bypass sends real data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_valid_ff <= 1'b0;
         out_real_ff <= 1'b0;
         out_i_ff <= 16'h0000;
         out_q_ff <= 16'h0000;
      end else if (dec == DNSD_BYPASS) begin
         out_valid_ff <= in_valid;
         out_real_ff <= 1'b1;
         if (in_valid) out_i_ff <= {adc_real, 3'h0, overrange_flag_i};
         out_q_ff <= 16'h0000;
      end else begin
         out_valid_ff <= ve;
         out_real_ff <= 1'b0;
         if (ve) begin
            out_i_ff <= {ie, overrange_flag_i};
            out_q_ff <= {qe, overrange_flag_q};
         end
      end
   end

   // ======================================
   // Checks
   logic [5:0] gap_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) gap_ff <= 6'h00;
      else if (out_valid_ff) gap_ff <= 6'h01;
      else if (gap_ff != 6'h00 && gap_ff != 6'h3f) gap_ff <= gap_ff + 6'h01;
   end

   sref_align_a: assert property (@(posedge pclk) disable iff (!presetn)
      sref_rise && arm_ff |=> nco_align_ff && align_cnt_ff == $past(align_cnt_ff) + 8'h01)
      else $error("SYSREF edge while armed did not align");
   arm_once_a: assert property (@(posedge pclk) disable iff (!presetn)
      sref_rise && arm_ff && !arm_wr |=> !arm_ff)
      else $error("Arm flag survived its SYSREF edge");
   pin_align_a: assert property (@(posedge pclk) disable iff (!presetn)
      sync_rise && pin_en && hs_ff != DNSD_HS_IDLE |=> nco_align_ff && hs_ff == DNSD_HS_IDLE)
      else $error("Rising SYNC did not align");
   pin_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      sync_rise && !pin_en && !(sref_rise && arm_ff) |=> !nco_align_ff)
      else $error("Alignment without pin alignment enabled");
   cgs_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      hs_ff == DNSD_HS_IDLE && sync_fall && link_en && !enc64
      |=> cgs_start_ff && hs_ff == DNSD_HS_CGS ##1 !cgs_start_ff)
      else $error("SYNC low did not start code group sync");
   trig_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
      hs_ff == DNSD_HS_IDLE && sync_fall && link_en && enc64 |=> hs_ff == DNSD_HS_TRIG
      && !cgs_start_ff)
      else $error("SYNC low did not arm trigger");
   dec4_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
      out_valid_ff && dec == DNSD_DEC4 && $stable(ctrl_ff) |-> gap_ff == 6'h00
      || gap_ff >= 6'h04)
      else $error("Decimate-by-4 output came too soon");
   bypass_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
      dec == DNSD_BYPASS && in_valid && $stable(ctrl_ff) |=> out_valid_ff && out_real_ff
      && out_i_ff[15:4] == $past(adc_real))
      else $error("Bypass sample not passed at full rate");
   apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready_ff ##1 !pready_ff)
      else $error("APB answer not in one cycle");
endmodule // dnsd_top

// [tb.sv]
// Self-checking bench for the DDC sync and decimation block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, sysref_pin, in_valid, ovr_i, ovr_q, sr_man;
   logic link_go, enc64, sr_run, er, pready_ff, pslverr_ff, sync_pin, cgs_start_ff;
   logic nco_align_ff, out_valid_ff, out_real_ff;
   logic [7:0] paddr, hold, sr_cnt, c0;
   logic [31:0] pwdata, prdata_ff, rd, fa, fb;
   logic [15:0] pa, pb, out_i_ff, out_q_ff;
   logic signed [14:0] mix_i, mix_q;
   logic [11:0] adc_real;
   int err_count, samples_checked, nc, na, nv, d;
   // ======================================
   // Device and receiver model
   dnsd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff),
      .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .sync_pin(sync_pin),
      .sysref_pin(sysref_pin), .cgs_start_ff(cgs_start_ff), .nco_align_ff(nco_align_ff),
      .osc_freq_word_chan_a_ff(fa), .osc_freq_word_chan_b_ff(fb),
      .osc_phase_word_chan_a_ff(pa), .osc_phase_word_chan_b_ff(pb),
      .in_valid(in_valid), .mix_i(mix_i), .mix_q(mix_q), .adc_real(adc_real),
      .overrange_flag_i(ovr_i), .overrange_flag_q(ovr_q), .out_valid_ff(out_valid_ff),
      .out_real_ff(out_real_ff), .out_i_ff(out_i_ff), .out_q_ff(out_q_ff));
   dnsd_rx_model u_rx (.pclk(pclk), .presetn(presetn), .link_go(link_go), .enc64(enc64),
      .hold(hold), .cgs_start_ff(cgs_start_ff), .sync_pin(sync_pin));
   // ======================================
   // Clock, and a free-running SYSREF with a long period of 16 cycles
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Scenarios ask for single pulses through sr_man, so this block alone drives the pin
   always @(posedge pclk) begin
      sr_cnt <= sr_run ? sr_cnt + 8'h01 : 8'h00;
      sysref_pin <= sr_run ? sr_cnt[3] : sr_man;
   end
   // ======================================
   // Shared tasks
   task chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task finish_test;
      if (err_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // One APB transfer; request held until pready is seen, bounded wait
   task apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready_ff !== 1'b1 && n < 16);
      rd = prdata_ff;
      er = pslverr_ff;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready_ff !== 1'b1) begin
         err_count++;
         finish_test;
      end else begin
         // One idle edge, so a following call never reassigns psel in this time step
         @(posedge pclk);
      end
   endtask
   // Count one-cycle pulses of the device outputs over a window
   task watch(input int cyc);
      nc = 0;
      na = 0;
      nv = 0;
      repeat (cyc) begin
         @(posedge pclk);
         nc += (cgs_start_ff === 1'b1);
         na += (nco_align_ff === 1'b1);
         nv += (out_valid_ff === 1'b1);
      end
   endtask
   // ======================================
   // Scenarios
   task tregs;
      chk({27'h0, pready_ff, pslverr_ff, cgs_start_ff, nco_align_ff, out_valid_ff}, 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 8'h14, 32'hdead_beef);
      apb(1'b0, 8'h14, 32'h0);
      chk(rd, 32'hdead_beef);
      chk(fb, 32'hdead_beef);
      apb(1'b1, 8'h1c, 32'hffff_ffff);
      apb(1'b0, 8'h1c, 32'h0);
      chk(rd, 32'h0000_ffff);
      chk({16'h0, pb}, 32'h0000_ffff);
      apb(1'b1, 8'h00, 32'hffff_ffff);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0000_0077);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h08, 32'hffff_ffff);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h0c, 32'h0);
      chk({er, rd[30:0]}, 32'h8000_0000);
      apb(1'b1, 8'h20, 32'h1);
      chk({31'h0, er}, 32'h1);
   endtask
   task tsync(input logic e, a, l, input logic [7:0] h, input int ec, ea);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h10, 32'h1234_5678);
      chk(fa, 32'h1234_5678);
      enc64 <= e;
      hold <= h;
      apb(1'b1, 8'h00, {29'h0, e, a, l});
      link_go <= 1'b1;
      watch(120);
      chk(32'(nc), 32'(ec));
      chk(32'(na), 32'(ea));
      link_go <= 1'b0;
      watch(8);
   endtask
   task tsys;
      int n;
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b1, 8'h18, 32'h0000_0abc);
      chk({16'h0, pa}, 32'h0000_0abc);
      apb(1'b0, 8'h08, 32'h0);
      c0 = rd[15:8];
      chk({24'h0, c0}, 32'h2);
      apb(1'b1, 8'h04, 32'h1);
      apb(1'b0, 8'h08, 32'h0);
      chk({31'h0, rd[0]}, 32'h1);
      sr_man <= 1'b1;
      watch(4);
      n = na;
      sr_man <= 1'b0;
      watch(20);
      chk(32'(n + na), 32'h1);
      apb(1'b0, 8'h08, 32'h0);
      chk({23'h0, rd[15:8], rd[0]}, {23'h0, c0 + 8'h01, 1'b0});
      sr_man <= 1'b1;
      watch(4);
      n = na;
      sr_man <= 1'b0;
      watch(20);
      chk(32'(n + na), 32'h0);
      sr_run <= 1'b1;
      n = 0;
      while (sr_cnt !== 8'h09 && n < 40) begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, n < 40}, 32'h1);
      apb(1'b1, 8'h04, 32'h1);
      watch(64);
      chk(32'(na), 32'h1);
      sr_run <= 1'b0;
   endtask
   // Constant input: unity-gain half-band chain settles to the input value
   task tdec(input logic [2:0] code, input int r);
      apb(1'b1, 8'h00, {25'h0, code, 4'h0});
      mix_i <= 15'sd1000;
      mix_q <= -15'sd1000;
      ovr_i <= 1'b1;
      ovr_q <= 1'b0;
      in_valid <= 1'b1;
      watch(1500);
      watch(1024);
      in_valid <= 1'b0;
      chk(32'(nv), 32'(1024 / r));
      d = int'($signed(out_i_ff[15:1])) - 1000;
      chk({31'h0, d >= -3 && d <= 3}, 32'h1);
      d = int'($signed(out_q_ff[15:1])) + 1000;
      chk({31'h0, d >= -3 && d <= 3}, 32'h1);
      chk({30'h0, out_i_ff[0], out_q_ff[0]}, 32'h2);
   endtask
   task tbyp;
      apb(1'b1, 8'h00, 32'h0);
      watch(4);
      adc_real <= 12'ha5c;
      ovr_i <= 1'b1;
      in_valid <= 1'b1;
      @(posedge pclk);
      in_valid <= 1'b0;
      @(posedge pclk);
      chk({30'h0, out_valid_ff, out_real_ff}, 32'h3);
      chk({out_i_ff, out_q_ff}, {12'ha5c, 3'h0, 1'b1, 16'h0});
   endtask
   // ======================================
   // Main sequence
   initial begin
      {psel, penable, pwrite, sr_man, in_valid, ovr_i, ovr_q} = 7'h00;
      {link_go, enc64, sr_run} = 3'h0;
      {paddr, hold, pwdata} = 48'h0;
      {mix_i, mix_q, adc_real} = 42'h0;
      err_count = 0;
      samples_checked = 0;
      presetn = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      tregs;
      tsync(1'b0, 1'b1, 1'b1, 8'h03, 1, 1);
      tsync(1'b0, 1'b0, 1'b1, 8'h3c, 1, 0);
      tsync(1'b1, 1'b1, 1'b1, 8'h05, 0, 1);
      tsync(1'b0, 1'b1, 1'b0, 8'h03, 0, 0);
      tsys;
      tdec(3'h1, 4);
      tdec(3'h2, 8);
      tdec(3'h3, 16);
      tdec(3'h4, 32);
      tbyp;
      finish_test;
   end
endmodule // tb
